// ---- hw/motor_starter_io.sv ----
// Purpose: Process-data bits, contactor control and diagnostics of a motor starter
// Assumes: Pins are synchronised here; master bits arrive on clk
// Notes:   Reset is synchronous, active low
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "starter_regs.svh"

// Overview of operation
// [R1] Ready bit high when ready for automatic operation, else low.
// [R2] Group bit low on fault, high when no fault.
// [R3] Sensor inputs copied onto input bits two and three.
// [R4] Forward contactor follows forward command bit.
// [R5] Reverse contactor follows reverse command bit.
// [R6] Both command bits high means fault reset, never both contactors.
// [R7] Auxiliary output follows the aux command bit while there is no motor overload.
// [R8] Forward and reverse contactors are never on together.
// [R9] Sensor supply overload or short raises group error.
// [R10] Replacement unit takes over stored slave address automatically.
// [R11] Detailed diagnostic status readable through parameter channel.
// [R12] Key modes auto, off, manual; manual runs from direction selector.
// [R13] Rotation direction swapped by configuration switch.
// [R14] After 24 V return in manual, no restart until key set off.
// [R15] Jumper closed: thermistor or plug fault clears ready, not group.
// [R16] Contactors held released while group error is active until reset.
module motor_starter_io (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 fwd_cmd_bit,
	input  wire logic                 rev_cmd_bit,
	input  wire logic                 aux_out_bit,
	output logic                      ready_auto_bit,
	output logic                      group_ok_bit,
	output logic                      sensor_a_bit,
	output logic                      sensor_b_bit,
	input  wire logic                 sensor_a_input,
	input  wire logic                 sensor_b_input,
	input  wire logic                 sensor_supply_fault,
	input  wire logic                 motor_overload,
	input  wire logic                 thermistor_trip,
	input  wire logic                 motor_plug_missing,
	input  wire logic                 aux_supply_ok,
	input  wire starter_pkg::key_mode_t operating_key_switch,
	input  wire starter_pkg::run_dir_t  direction_selector,
	input  wire logic [4:0]           bus_slave_addr,
	input  wire logic                 bus_addr_valid,
	output logic                      forward_run,
	output logic                      reverse_run,
	output logic                      aux_actuator_output,
	output logic [4:0]                slave_addr,
	input  wire logic [3:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [31:0]               reg_rdata,
	output logic                      irq
);
	import starter_pkg::*;

	// Pin synchronisers: stage one is read only by stage two
	logic [10:0] sync1_r;
	logic [10:0] sync2_r;
	logic [10:0] pins;
	assign pins = {sensor_a_input, sensor_b_input, sensor_supply_fault, motor_overload,
		thermistor_trip, motor_plug_missing, aux_supply_ok, operating_key_switch,
		direction_selector};

	logic       s_sen_a;
	logic       s_sen_b;
	logic       s_supply;
	logic       s_ovl;
	logic       s_therm;
	logic       s_plug;
	logic       s_aux_ok;
	key_mode_t  s_mode;
	run_dir_t   s_dir;
	assign s_sen_a  = sync2_r[10];
	assign s_sen_b  = sync2_r[9];
	assign s_supply = sync2_r[8];
	assign s_ovl    = sync2_r[7];
	assign s_therm  = sync2_r[6];
	assign s_plug   = sync2_r[5];
	assign s_aux_ok = sync2_r[4];
	assign s_mode   = key_mode_t'(sync2_r[3:2]);
	assign s_dir    = run_dir_t'(sync2_r[1:0]);

	// State
	logic [1:0]  ctrl_r;
	logic [1:0]  ctrl_nxt;
	logic        fault_r;
	logic        fault_nxt;
	logic        hand_lock_r;
	logic        hand_lock_nxt;
	logic        aux_ok_d_r;
	logic        aux_ok_d_nxt;
	logic [2:0]  irq_stat_r;
	logic [2:0]  irq_stat_nxt;
	logic [2:0]  irq_mask_r;
	logic [2:0]  irq_mask_nxt;
	logic [4:0]  addr_r;
	logic [4:0]  addr_nxt;
	logic [31:0] rdata_nxt;
	logic        fwd_r;
	logic        fwd_nxt;
	logic        rev_r;
	logic        rev_nxt;
	logic        aux_r;
	logic        aux_nxt;
	logic [3:0]  inbits_r;
	logic [3:0]  inbits_nxt;

	// Swaps the contactor pair when anticlockwise rotation is configured
	function automatic logic [1:0] orient(input logic f, input logic r, input logic acw);
		orient = acw ? {f, r} : {r, f};
	endfunction

	logic       jumper;
	logic       plug_fault;
	logic       group_fault;
	logic       reset_cmd;
	logic       want_f;
	logic       want_r;
	logic [1:0] drive;
	logic       ready;

	always_comb begin
		jumper      = ctrl_r[`CTRL_JUMPER_BIT];
		plug_fault  = s_therm | s_plug;
		// Jumper diverts motor-side faults into the ready bit
		group_fault = s_ovl | s_supply | ~s_aux_ok | (plug_fault & ~jumper); // see [R9] [R15]
		reset_cmd   = fwd_cmd_bit & rev_cmd_bit; // see [R6]
		fault_nxt   = fault_r;
		if (group_fault)
			fault_nxt = 1'b1;
		else if (reset_cmd)
			fault_nxt = 1'b0;
		hand_lock_nxt = hand_lock_r;
		aux_ok_d_nxt  = s_aux_ok;
		// Supply return while in hand latches a lock; key to off clears it
		if (s_aux_ok & ~aux_ok_d_r & (s_mode == MODE_HAND))
			hand_lock_nxt = 1'b1; // see [R14]
		else if (s_mode == MODE_OFF)
			hand_lock_nxt = 1'b0; // see [R14]
		want_f = 1'b0;
		want_r = 1'b0;
		unique case (s_mode)
			MODE_AUTO: begin
				want_f = fwd_cmd_bit & ~rev_cmd_bit; // see [R4] [R6]
				want_r = rev_cmd_bit & ~fwd_cmd_bit; // see [R5] [R6]
			end
			MODE_HAND: begin
				want_f = (s_dir == RUN_FWD) & ~hand_lock_r; // see [R12]
				want_r = (s_dir == RUN_REV) & ~hand_lock_r; // see [R12]
			end
			default: begin
			end
		endcase
		// A direction change passes through both released for one cycle
		if (fault_r | group_fault) begin
			want_f = 1'b0; // see [R16]
			want_r = 1'b0; // see [R16]
		end
		drive   = orient(want_f, want_r, ctrl_r[`CTRL_ACW_BIT]); // see [R13]
		fwd_nxt = drive[0] & ~rev_r & ~drive[1]; // see [R8]
		rev_nxt = drive[1] & ~fwd_r & ~drive[0]; // see [R8]
		aux_nxt = aux_out_bit & ~s_ovl; // see [R7]
		ready   = (s_mode == MODE_AUTO) & ~(jumper & plug_fault); // see [R1] [R15]
		inbits_nxt = {s_sen_b, s_sen_a, ~(fault_r | group_fault), ready}; // see [R1] [R2] [R3]
		// Address follows the master's assignment so a swapped unit inherits it
		addr_nxt = bus_addr_valid ? bus_slave_addr : addr_r; // see [R10]
		ctrl_nxt     = ctrl_r;
		irq_mask_nxt = irq_mask_r;
		irq_stat_nxt = irq_stat_r;
		if (reg_wr && reg_addr == `ADDR_CTRL)
			ctrl_nxt = reg_wdata[1:0];
		if (reg_wr && reg_addr == `ADDR_IRQ_MASK)
			irq_mask_nxt = reg_wdata[2:0];
		if (reg_wr && reg_addr == `ADDR_IRQ_STAT)
			irq_stat_nxt = irq_stat_r & ~reg_wdata[2:0];
		// Set wins over a clear in the same cycle
		if (group_fault & ~fault_r)
			irq_stat_nxt[`IRQ_FAULT_BIT] = 1'b1;
		if (reset_cmd & fault_r & ~group_fault)
			irq_stat_nxt[`IRQ_RESET_BIT] = 1'b1;
		if (s_supply)
			irq_stat_nxt[`IRQ_SUPPLY_BIT] = 1'b1;
		rdata_nxt = 32'h0;
		if (reg_rd) begin
			unique case (reg_addr)
				`ADDR_CTRL:       rdata_nxt = {30'h0, ctrl_r};
				`ADDR_STATUS:     rdata_nxt = {26'h0, rev_r, fwd_r, inbits_r};
				// Detailed diagnosis beyond the group bit
				`ADDR_DIAG:       rdata_nxt = {24'h0, hand_lock_r, fault_r, s_aux_ok,
					s_plug, s_therm, s_supply, s_ovl, group_fault}; // see [R11]
				`ADDR_IRQ_STAT:   rdata_nxt = {29'h0, irq_stat_r};
				`ADDR_IRQ_MASK:   rdata_nxt = {29'h0, irq_mask_r};
				`ADDR_SLAVE_ADDR: rdata_nxt = {27'h0, addr_r};
				default:          rdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		sync1_r <= pins;
		sync2_r <= sync1_r;
		if (!rst_n) begin
			ctrl_r      <= `CTRL_RESET;
			fault_r     <= 1'b0;
			hand_lock_r <= 1'b1;
			aux_ok_d_r  <= 1'b0;
			irq_stat_r  <= 3'h0;
			irq_mask_r  <= `IRQ_MASK_RESET;
			addr_r      <= `SLAVE_ADDR_RESET;
			reg_rdata   <= 32'h0;
			fwd_r       <= 1'b0;
			rev_r       <= 1'b0;
			aux_r       <= 1'b0;
			inbits_r    <= 4'h0;
		end else begin
			ctrl_r      <= ctrl_nxt;
			fault_r     <= fault_nxt;
			hand_lock_r <= hand_lock_nxt;
			aux_ok_d_r  <= aux_ok_d_nxt;
			irq_stat_r  <= irq_stat_nxt;
			irq_mask_r  <= irq_mask_nxt;
			addr_r      <= addr_nxt;
			reg_rdata   <= rdata_nxt;
			fwd_r       <= fwd_nxt;
			rev_r       <= rev_nxt;
			aux_r       <= aux_nxt;
			inbits_r    <= inbits_nxt;
		end
	end

	assign forward_run         = fwd_r;
	assign reverse_run         = rev_r;
	assign aux_actuator_output = aux_r;
	assign ready_auto_bit      = inbits_r[0];
	assign group_ok_bit        = inbits_r[1];
	assign sensor_a_bit        = inbits_r[2];
	assign sensor_b_bit        = inbits_r[3];
	assign slave_addr          = addr_r;
	assign irq                 = |(irq_stat_r & irq_mask_r);
endmodule

// ---- hw/starter_regs.svh ----
// Purpose: Constants for the motor starter process-data block
// Assumes: 250 MHz clock
// Notes:   Offsets index 32-bit words on the plain register port
`ifndef STARTER_REGS_SVH
`define STARTER_REGS_SVH
`define CLK_PERIOD_NS       4
`define ADDR_CTRL           4'h0
`define ADDR_STATUS         4'h1
`define ADDR_DIAG           4'h2
`define ADDR_IRQ_STAT       4'h3
`define ADDR_IRQ_MASK       4'h4
`define ADDR_SLAVE_ADDR     4'h5
`define CTRL_JUMPER_BIT     0
`define CTRL_ACW_BIT        1
`define CTRL_RESET          2'h0
`define IRQ_FAULT_BIT       0
`define IRQ_RESET_BIT       1
`define IRQ_SUPPLY_BIT      2
`define IRQ_MASK_RESET      3'h0
`define SLAVE_ADDR_RESET    5'h00
`define DEBOUNCE_NS         1000
`define DEBOUNCE_CYC        ((`DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- hw/starter_pkg.sv ----
// Purpose: Types for the motor starter process-data block
// Assumes: Nothing beyond the constants header
// Notes:   Gray codes along the usual mode path
package starter_pkg;
	typedef enum logic [1:0] {
		MODE_OFF  = 2'b00,
		MODE_AUTO = 2'b01,
		MODE_HAND = 2'b11
	} key_mode_t;
	typedef enum logic [1:0] {
		RUN_STOP = 2'b00,
		RUN_FWD  = 2'b01,
		RUN_REV  = 2'b11
	} run_dir_t;
endpackage

// ---- verif/motor_starter_io_properties.sv ----
// Purpose: Port checks for the motor starter block
// Assumes: One clock, synchronous active-low reset
// Notes:   Pin effects take three edges through synchronisers
`timescale 1ns/1ps
module motor_starter_io_properties (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        fwd_cmd_bit,
	input wire logic        rev_cmd_bit,
	input wire logic        aux_out_bit,
	input wire logic        ready_auto_bit,
	input wire logic        group_ok_bit,
	input wire logic        sensor_a_bit,
	input wire logic        sensor_a_input,
	input wire logic        sensor_supply_fault,
	input wire logic        forward_run,
	input wire logic        reverse_run,
	input wire logic        aux_actuator_output,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_run_exclusive: assert property (!(forward_run && reverse_run))
		else $error("both contactors on");
	chk_reset_cmd_idle: assert property (ready_auto_bit && $past(fwd_cmd_bit == rev_cmd_bit)
		|-> !forward_run && !reverse_run) else $error("contactor on without one command");
	chk_run_cause: assert property ((forward_run || reverse_run) && ready_auto_bit
		|-> $past(fwd_cmd_bit ^ rev_cmd_bit)) else $error("run without a command");
	chk_supply_group: assert property (sensor_supply_fault [*3] |=> !group_ok_bit)
		else $error("supply overload not reported");
	// Two low samples; the group bit drops on the same edge that releases the contactors
	chk_fault_idle: assert property (!group_ok_bit && $past(!group_ok_bit)
		|-> !forward_run && !reverse_run) else $error("contactor on during fault");
	chk_aux_off: assert property (!aux_out_bit |=> !aux_actuator_output)
		else $error("aux output on without command");
	chk_sensor_copy: assert property ($past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n)
		|-> sensor_a_bit == $past(sensor_a_input, 3)) else $error("sensor bit wrong");
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read answer");
endmodule
bind motor_starter_io motor_starter_io_properties i_chk (.*);

// ---- verif/as_master_model.sv ----
// Purpose: Bus master side that sets the three command bits
// Assumes: Bits change right after a rising edge
// Notes:   A fault reset is both direction bits high together
`timescale 1ns/1ps
module as_master_model (
	input  wire logic       clk,
	input  wire logic [2:0] req,
	output logic            fwd_cmd_bit = 1'h0,
	output logic            rev_cmd_bit = 1'h0,
	output logic            aux_out_bit = 1'h0
);
	// Whole pattern moves on one edge, never a half-changed pair
	always @(posedge clk)
		{aux_out_bit, rev_cmd_bit, fwd_cmd_bit} <= req;
endmodule

// ---- verif/test_motor_starter_io.sv ----
// Purpose: Self-checking bench for the motor starter block
// Assumes: Master bits come from the partner model
// Notes:   Overload and plug pins stay tied
`timescale 1ns/1ps
module test_motor_starter_io;
	import starter_pkg::*;
	logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, bus_addr_valid = 0;
	logic        sensor_a_input = 0, sensor_b_input = 0, sensor_supply_fault = 0;
	logic        motor_overload = 0, thermistor_trip = 0, motor_plug_missing = 0;
	logic        aux_supply_ok = 1, fwd_cmd_bit, rev_cmd_bit, aux_out_bit, irq;
	logic        ready_auto_bit, group_ok_bit, sensor_a_bit, sensor_b_bit;
	logic        forward_run, reverse_run, aux_actuator_output;
	logic [2:0]  req = 3'h0;
	logic [3:0]  reg_addr = 4'h0;
	logic [4:0]  bus_slave_addr = 5'h00, slave_addr, sa;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	key_mode_t   operating_key_switch = MODE_OFF;
	run_dir_t    direction_selector = RUN_STOP;
	int          fail_count = 0, compares = 0, q[$];
	motor_starter_io i_dut (.*);
	as_master_model i_master (.clk, .req, .fwd_cmd_bit, .rev_cmd_bit, .aux_out_bit);
	initial forever #2 clk = ~clk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			fail_count++;
			$display("BAD at %0t: seen %h, expected %h", $time, seen, want);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		wt(1);
		reg_wr <= 1'h0;
		// Gap keeps a following write from re-raising the strobe in this step
		wt(1);
	endtask
	task automatic rreg(input logic [3:0] a, input logic [31:0] want);
		reg_addr <= a;
		reg_rd <= 1'h1;
		wt(1);
		reg_rd <= 1'h0;
		// Read data stand only until the next edge; look once they have settled
		#1;
		chk(reg_rdata, want);
	endtask
	// Expected {reverse, forward}; anticlockwise swaps the contactors
	function automatic int run_exp(input int c, input int acw);
		if (c == 1 || c == 2)
			return acw ? 3 - c : c;
		return 0;
	endfunction
	task automatic stop_test;
		$display("compares %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		sa = 5'($urandom(38));
		wt(5);
		rst_n <= 1'h1;
		wt(4);
		rreg(4'h2, 32'h20);
		rreg(4'hF, 32'h0);
		operating_key_switch <= MODE_HAND;
		direction_selector <= RUN_FWD;
		wt(5);
		chk(forward_run, 1);
		aux_supply_ok <= 1'h0;
		wt(5);
		aux_supply_ok <= 1'h1;
		wt(5);
		req <= 3'h3;
		wt(5);
		req <= 3'h0;
		wt(5);
		chk(forward_run, 0);
		operating_key_switch <= MODE_OFF;
		wt(5);
		operating_key_switch <= MODE_HAND;
		wt(5);
		chk(forward_run, 1);
		wreg(4'h3, 32'h7);
		$display("manual mode test done");
		operating_key_switch <= MODE_AUTO;
		wt(5);
		for (int c = 0; c < 8; c++) begin
			req <= 3'(c);
			wt(4);
			chk({aux_actuator_output, reverse_run, forward_run}, (c & 4) | run_exp(c & 3, 0));
		end
		wreg(4'h0, 32'h2);
		req <= 3'h1;
		wt(4);
		chk({ready_auto_bit, reverse_run, forward_run}, 4 | run_exp(1, 1));
		wreg(4'h0, 32'h0);
		$display("command test done");
		wreg(4'h4, 32'h4);
		sensor_supply_fault <= 1'h1;
		wt(5);
		chk({irq, group_ok_bit, reverse_run, forward_run}, 8);
		rreg(4'h3, 32'h5);
		sensor_supply_fault <= 1'h0;
		req <= 3'h3;
		wt(5);
		req <= 3'h0;
		wreg(4'h3, 32'h7);
		wt(2);
		chk({irq, group_ok_bit}, 1);
		wreg(4'h0, 32'h1);
		thermistor_trip <= 1'h1;
		wt(5);
		chk({ready_auto_bit, group_ok_bit}, 1);
		thermistor_trip <= 1'h0;
		bus_slave_addr <= sa;
		bus_addr_valid <= 1'h1;
		wt(1);
		bus_addr_valid <= 1'h0;
		wt(2);
		chk(slave_addr, sa);
		$display("fault and address test done");
		repeat (40) begin
			if (q.size() == 4)
				chk({sensor_b_bit, sensor_a_bit}, q.pop_front());
			q.push_back($urandom % 4);
			{sensor_b_input, sensor_a_input} <= 2'(q[$]);
			wt(1);
		end
		$display("sensor test done");
		stop_test;
	end
	initial begin
		wt(2000);
		fail_count++;
		stop_test;
	end
endmodule
